// *** reset_cause_pkg.sv ***
// Package with register layout and timing constants for the reset cause and power-on-clear block.
package reset_cause_pkg;
  localparam logic [15:0] CAUSE_REG_ADDR = 16'hFFAC;
  localparam int CAUSE_WIDTH = 8;
  localparam logic [7:0] CAUSE_RESET_VALUE = 8'h00;
  localparam int WATCHDOG_BIT = 4;
  localparam int LOWVOLT_BIT = 0;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_FREQ_HZ = 50000000;
  // Stabilization wait window in microseconds.
  localparam int STAB_MIN_US = 1930;
  localparam int STAB_MAX_US = 5390;
  // The least wait rounds up to whole cycles.
  localparam int STAB_MIN_CYCLES = (STAB_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_MAX_CYCLES = (STAB_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
endpackage

// *** stab_timer.sv ***
// Down counter that produces the supply stabilization wait.
`timescale 1ns/1ps
`default_nettype none
module stab_timer #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control
  input wire logic restart_i,
  input wire logic [WIDTH-1:0] load_i,
  // Status
  output logic done_o
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic done;
  } timer_s;

  timer_s state_reg;
  timer_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (restart_i)
    begin
      state_next.count = load_i;
      state_next.done = 1'b0;
    end
    else if (state_reg.count != '0)
    begin
      state_next.count = state_reg.count - 1'b1;
    end
    else
    begin
      state_next.done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign done_o = state_reg.done;
endmodule // stab_timer
`default_nettype wire

// *** reset_cause.sv ***
// Reset cause register and power-on-clear reset generator.
`timescale 1ns/1ps
`default_nettype none
module reset_cause #(
  parameter int STAB_CYCLES = reset_cause_pkg::STAB_MIN_CYCLES,
  parameter int TIMER_WIDTH = 18
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Reset sources
  input wire logic ext_reset_n_i,
  input wire logic watchdog_req_i,
  input wire logic lowvolt_req_i,
  // Supply comparators and option setting
  input wire logic supply_above_low_i,
  input wire logic supply_above_high_i,
  input wire logic poweron_threshold_select_i,
  // Processor read port
  input wire logic rd_en_i,
  input wire logic [15:0] addr_i,
  output logic [7:0] rd_data_o,
  // Reset outputs
  output logic poweron_reset_o,
  output logic internal_reset_o
);
  typedef enum logic [2:0] {
    POC_HOLD = 3'b001,
    POC_WAIT = 3'b010,
    POC_RUN = 3'b100
  } poc_state_e;

  // Read data is registered and shows zero in any cycle that follows no read.
  typedef struct packed {
    poc_state_e poweron_clear_unit;
    logic timer_armed;
    logic watchdog_cause_flag;
    logic lowvolt_cause_flag;
    logic [7:0] rd_data;
    logic poc_reset;
    logic int_reset;
  } core_s;

  core_s state_reg;
  core_s state_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic timer_restart;
  logic timer_done;
  logic cause_read;

  logic release_ok;
  logic pin_reset;
  logic cause_req;
  logic [7:0] cause_byte;

  // The reset release is synchronised so no flop leaves reset on a ragged edge.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Reads of any other address are refused quietly and return zero.
  assign cause_read = rd_en_i && (addr_i == reset_cause_pkg::CAUSE_REG_ADDR);
  // Active-high views of the reset sources.
  assign pin_reset = !ext_reset_n_i;
  assign cause_req = watchdog_req_i || lowvolt_req_i;

  // Option 1 needs the higher level, option 0 only the low level.
  assign release_ok = supply_above_low_i
    && (!poweron_threshold_select_i || supply_above_high_i);

  // Restart the wait whenever the supply is below the low level.
  // The timer leaves reset already expired, so the first cycle after reset reloads it;
  // otherwise a supply that is already up would skip the stabilization wait.
  assign timer_restart = !supply_above_low_i || !state_reg.timer_armed;

  // Unused bits of the cause register always read as zero.
  always_comb
  begin
    cause_byte = reset_cause_pkg::CAUSE_RESET_VALUE;
    cause_byte[reset_cause_pkg::WATCHDOG_BIT] = state_reg.watchdog_cause_flag;
    cause_byte[reset_cause_pkg::LOWVOLT_BIT] = state_reg.lowvolt_cause_flag;
  end

  // The wait runs from the low level, so a slow climb to the higher level may use it all up.
  stab_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_stab_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .restart_i(timer_restart),
    .load_i(TIMER_WIDTH'(STAB_CYCLES)),
    .done_o(timer_done)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.timer_armed = 1'b1;
    state_next.rd_data = 8'h00;
    case (state_reg.poweron_clear_unit)
      // Wait here until the release level for the selected option is reached.
      POC_HOLD:
      begin
        if (release_ok)
        begin
          state_next.poweron_clear_unit = POC_WAIT;
        end
      end

      // Count out the stabilization wait; a dip below the low level starts over.
      POC_WAIT:
      begin
        if (!supply_above_low_i)
        begin
          state_next.poweron_clear_unit = POC_HOLD;
        end
        else if (timer_done)
        begin
          state_next.poweron_clear_unit = POC_RUN;
        end
      end

      // Normal running until the supply falls below the low level.
      POC_RUN:
      begin
        if (!supply_above_low_i)
        begin
          state_next.poweron_clear_unit = POC_HOLD;
        end
      end

      default:
      begin
        state_next.poweron_clear_unit = POC_HOLD;
      end
    endcase
    // The power-on-clear reset stands in every state but normal running.
    state_next.poc_reset = (state_next.poweron_clear_unit != POC_RUN);

    // A read takes the old value and clears; a new request in the same cycle still wins.
    if (cause_read)
    begin
      state_next.rd_data = cause_byte;
      state_next.watchdog_cause_flag = 1'b0;
      state_next.lowvolt_cause_flag = 1'b0;
    end

    if (watchdog_req_i)
    begin
      state_next.watchdog_cause_flag = 1'b1;
    end

    if (lowvolt_req_i)
    begin
      state_next.lowvolt_cause_flag = 1'b1;
    end

    // Pin and power-on-clear resets dominate every other source.
    if (pin_reset || state_next.poc_reset)
    begin
      state_next.watchdog_cause_flag = 1'b0;
      state_next.lowvolt_cause_flag = 1'b0;
    end

    // Held while any source is active, so it drops only once the last one has gone.
    if (pin_reset || state_next.poc_reset || cause_req)
    begin
      state_next.int_reset = 1'b1;
    end
    else
    begin
      state_next.int_reset = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg.poweron_clear_unit <= POC_HOLD;
      state_reg.timer_armed <= 1'b0;
      state_reg.watchdog_cause_flag <= 1'b0;
      state_reg.lowvolt_cause_flag <= 1'b0;
      state_reg.rd_data <= reset_cause_pkg::CAUSE_RESET_VALUE;
      state_reg.poc_reset <= 1'b1;
      state_reg.int_reset <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Every output is taken straight from the state register.
  assign rd_data_o = state_reg.rd_data;
  assign poweron_reset_o = state_reg.poc_reset;
  assign internal_reset_o = state_reg.int_reset;
endmodule // reset_cause
`default_nettype wire

// *** reset_cause_sva.sv ***
// Checker for the reset cause block ports.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_sva (
  // Ports
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ext_reset_n_i,
  input wire logic watchdog_req_i,
  input wire logic lowvolt_req_i,
  input wire logic supply_above_low_i,
  input wire logic rd_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic poweron_reset_o,
  input wire logic internal_reset_o
);
  wire ok = ext_reset_n_i && !poweron_reset_o;
  wire rd = rd_en_i && addr_i == 16'hFFAC;
  wire qt = !watchdog_req_i && !lowvolt_req_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd; rd && ok && qt; endsequence
  property p_idle; !rd |=> rd_data_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_clr; s_rd ##1 s_rd |=> rd_data_o == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_wd; watchdog_req_i && ok ##1 rd && ok |=> rd_data_o[4]; endproperty
  a_wd: assert property (p_wd) else $error("wd");
  property p_lv; lowvolt_req_i && ok ##1 rd && ok |=> rd_data_o[0]; endproperty
  a_lv: assert property (p_lv) else $error("lv");
  property p_pad; (rd_data_o & 8'hEE) == 8'h00; endproperty
  a_pad: assert property (p_pad) else $error("pad");
  property p_int; !ext_reset_n_i || !qt |=> internal_reset_o; endproperty
  a_int: assert property (p_int) else $error("int");
  property p_rel;
    ext_reset_n_i && qt && !poweron_reset_o && supply_above_low_i |=> !internal_reset_o;
  endproperty
  a_rel: assert property (p_rel) else $error("release");
  property p_low; !supply_above_low_i |=> poweron_reset_o; endproperty
  a_low: assert property (p_low) else $error("low");
  property p_stab; $rose(supply_above_low_i) |=> poweron_reset_o [*8]; endproperty
  a_stab: assert property (p_stab) else $error("wait");
endmodule // reset_cause_sva
bind reset_cause reset_cause_sva reset_cause_sva_inst (.*);
`default_nettype wire

// *** cpu_reader.sv ***
// Processor model that reads the cause register.
`timescale 1ns/1ps
`default_nettype none
module cpu_reader (
  // Bench side
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic [15:0] where_i,
  // Block side
  input wire logic [7:0] rd_data_i,
  output logic rd_en_o,
  output logic [15:0] addr_o,
  output logic [7:0] got_o
);
  initial {rd_en_o, addr_o} = '0;
  always @(negedge clk_sys_i)
  begin
    if (rd_en_o)
      got_o <= rd_data_i;
    rd_en_o <= go_i;
    // An idle bus inverts the address every cycle, so a stale address shows again on every other cycle.
    addr_o <= go_i ? where_i : ~addr_o;
  end
endmodule // cpu_reader
`default_nettype wire

// *** reset_cause_test.sv ***
// Bench for the reset cause block.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_test;
  logic clk_sys_i = 0, rstn_i = 0, ext_reset_n_i = 1, watchdog_req_i = 0, lowvolt_req_i = 0;
  logic supply_above_low_i = 1, supply_above_high_i = 1, poweron_threshold_select_i = 0;
  logic rd_en_i, poweron_reset_o, internal_reset_o, go = 0;
  logic [15:0] addr_i, where;
  logic [7:0] rd_data_o, got;
  int err_total = 0, checked = 0, seed = 66591, model = 0, n;
  always #10 clk_sys_i = ~clk_sys_i;
  reset_cause #(.STAB_CYCLES(10)) reset_cause_inst (.*);
  cpu_reader cpu_reader_inst (.clk_sys_i, .go_i(go), .where_i(where), .rd_data_i(rd_data_o),
    .rd_en_o(rd_en_i), .addr_o(addr_i), .got_o(got));
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    checked++;
    err_total += int'(a !== e);
    if (a !== e)
      $display("MISMATCH %0t %h not %h", $time, a, e);
  endtask
  task automatic chk_rst(input logic a, input logic e);
    checked++;
    err_total += int'(a !== e);
    if (a !== e)
      $display("MISMATCH %0t reset %b not %b", $time, a, e);
  endtask
  task automatic conclude;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input logic [7:0] r);
    where <= &r[7:6] ? 16'($random(seed)) & 16'hFFAB : 16'hFFAC;
    {ext_reset_n_i, watchdog_req_i, lowvolt_req_i} <= {!(&r[3:2]), r[5:4]};
    go <= 1;
    @(negedge clk_sys_i);
    {ext_reset_n_i, watchdog_req_i, lowvolt_req_i} <= 3'b100;
    model = &r[3:2] ? 0 : model | r[5] << 4 | r[4];
    repeat (r[0]) @(negedge clk_sys_i);
    go <= 0;
    repeat (2) @(negedge clk_sys_i);
    chk(got, &r[7:6] || r[0] ? 8'h00 : 8'(model));
    model = &r[7:6] ? model : 0;
  endtask
  initial
  begin
    repeat (6) @(negedge clk_sys_i);
    rstn_i <= 1;
    repeat (8) @(negedge clk_sys_i);
    chk_rst(poweron_reset_o, 1'b1);
    repeat (16) @(negedge clk_sys_i);
    chk_rst(poweron_reset_o, 1'b0);
    chk_rst(internal_reset_o, 1'b0);
    repeat (200) step(8'($random(seed)));
    $display("read test done");
    for (n = 0; n < 2; n++)
    begin
      poweron_threshold_select_i <= n[0];
      watchdog_req_i <= 1;
      supply_above_low_i <= 0;
      supply_above_high_i <= 0;
      @(negedge clk_sys_i);
      watchdog_req_i <= 0;
      repeat (3) @(negedge clk_sys_i);
      chk_rst(poweron_reset_o, 1'b1);
      chk_rst(internal_reset_o, 1'b1);
      supply_above_low_i <= 1;
      repeat (14) @(negedge clk_sys_i);
      chk_rst(poweron_reset_o, n[0]);
      chk_rst(internal_reset_o, n[0]);
      supply_above_high_i <= 1;
      repeat (14) @(negedge clk_sys_i);
      chk_rst(poweron_reset_o, 1'b0);
      chk_rst(internal_reset_o, 1'b0);
      model = 0;
      step(8'h00);
    end
    $display("power test done");
    conclude;
  end
  initial
  begin
    // The tests need about 1000 cycles; ten times that means a hang.
    #200000;
    err_total++;
    conclude;
  end
endmodule // reset_cause_test
`default_nettype wire
